// file: hw/pcrc_pkg.sv
// shared constants for the clock ratio and pll control block
package pcrc_pkg;
   localparam int unsigned ADDR_W = 32;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W = 8;
   localparam int unsigned MODE_W = 3;
   localparam int unsigned FR_W = 4;
   localparam int unsigned LOG_W = 3;
   localparam int unsigned DIV_W = 4;

   localparam logic [ADDR_W-1:0] ADDR_RATIO = 32'hfffffe90;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 32'hfffffe94;

   localparam int unsigned BIT_SECOND_PLL_OFF = 7;
   localparam int unsigned BIT_FIRST_PLL_OFF = 6;
   localparam int unsigned BIT_BUS_CLOCK_PIN_HIZ = 5;
   localparam int unsigned BIT_RESERVED = 4;
   localparam int unsigned FR_LSB = 0;

   localparam int unsigned STAT_SWITCHING = 0;
   localparam int unsigned STAT_MODE_LSB = 1;
   localparam int unsigned STAT_APPLIED_LSB = 4;

   localparam logic [REG_W-1:0] RESET_MODE01 = 8'h00;
   localparam logic [REG_W-1:0] RESET_MODE2 = 8'h40;
   localparam logic [REG_W-1:0] RESET_MODE3 = 8'h60;
   localparam logic [REG_W-1:0] RESET_MODE45 = 8'ha6;
   localparam logic [REG_W-1:0] RESET_MODE6 = 8'he0;

   localparam logic [REG_W-1:0] FIXED_NONE = 8'h00;
   localparam logic [REG_W-1:0] FIXED_MODE23 = 8'h40;
   localparam logic [REG_W-1:0] FIXED_MODE45 = 8'ha0;
   localparam logic [REG_W-1:0] FIXED_MODE6 = 8'he0;
   localparam logic [REG_W-1:0] RESERVED_MASK = 8'h10;

   localparam logic [MODE_W-1:0] MODE_0 = 3'h0;
   localparam logic [MODE_W-1:0] MODE_1 = 3'h1;
   localparam logic [MODE_W-1:0] MODE_2 = 3'h2;
   localparam logic [MODE_W-1:0] MODE_3 = 3'h3;
   localparam logic [MODE_W-1:0] MODE_4 = 3'h4;
   localparam logic [MODE_W-1:0] MODE_5 = 3'h5;
   localparam logic [MODE_W-1:0] MODE_6 = 3'h6;

   // rates as log2 of multiples of a quarter input clock: 0 = x1/4 ... 4 = x4
   localparam logic [LOG_W-1:0] RATE_Q = 3'h0;
   localparam logic [LOG_W-1:0] RATE_H = 3'h1;
   localparam logic [LOG_W-1:0] RATE_1 = 3'h2;
   localparam logic [LOG_W-1:0] RATE_2 = 3'h3;
   localparam logic [LOG_W-1:0] RATE_4 = 3'h4;
   localparam logic [LOG_W-1:0] RATE_TOP = 3'h4;

   localparam logic [FR_W-1:0] FR_ALL_ONE = 4'hf;
   localparam logic [FR_W-1:0] FR_BUS4_A = 4'hc;
   localparam logic [FR_W-1:0] FR_BUS4_B = 4'he;

   typedef enum logic {PCRC_RUN, PCRC_SETTLE} pcrc_state_t;
endpackage

// file: hw/pcrc_clk_div.sv
// enable-pulse divider for one internal clock
`timescale 1ns/100ps
module pcrc_clk_div #(
   parameter int unsigned CNT_W = pcrc_pkg::DIV_W
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic run,
   input wire logic [pcrc_pkg::LOG_W-1:0] shift,
   output logic clk_en
);
   import pcrc_pkg::*;

   initial
   begin
      if (CNT_W < int'(RATE_TOP))
         $error("pcrc_clk_div: CNT_W too small for the slowest rate");
   end

   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] reload;

   // period in reference cycles is 2**shift
   assign reload = CNT_W'((1 << shift) - 1);

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         count <= '0;
      else if (!run)
         count <= '0;
      else if (count == '0)
         count <= reload;
      else
         count <= count - 1'b1;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         clk_en <= 1'b0;
      else
         clk_en <= run && (count == '0);
   end
endmodule // pcrc_clk_div

// file: hw/pcrc_ctrl.sv
// clock ratio and pll control: register, ratio decode, switch sequence
// What this block does
// - only power-on reset initialises the ratio register; watchdog reset keeps it.
// - reset value from mode pins: 00, 40, 60, a6, e0 per mode.
// - bit 7 second pll off; writable modes 0-3, reads 1 in 4-6.
// - bit 6 first pll off; writable modes 0,1,4,5, reads 1 in 2,3,6.
// - bit 5 bus clock pin hi-z; writable modes 0-3, reads 1 in 4-6.
// - bit 4 reserved, reads 0; software writes 0.
// - both plls on: base x4, nine codes set core, bus, peripheral rates.
// - only second pll: base x1, x2 or x4; peripheral x1 or x2.
// - only first pll, modes 0/1: base x4, bus and peripheral x1.
// - modes 4/5 first pll: base x2, bus x1, four codes.
// - both plls off: base x1, ten codes divide to 1/4, 1/2, 1.
// - a changing write stops internal clocks and feeds the watchdog.
// - on watchdog overflow, new ratio starts; no flags, interrupt or output.
// - modes 4-6 use the shared pin as clock pause request.
// - external clock from oscillator pin in modes 0-3, bus clock pin otherwise.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/100ps
module pcrc_ctrl #(
   parameter int unsigned DIV_CNT_W = pcrc_pkg::DIV_W
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic watchdog_reset,
   input wire logic [pcrc_pkg::MODE_W-1:0] mode_pins,
   input wire logic [pcrc_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [pcrc_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [pcrc_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic watchdog_settle_overflow,
   output logic watchdog_count_enable,
   output logic watchdog_flags_suppress,
   output logic first_pll_run,
   output logic second_pll_run,
   output logic core_clk_en,
   output logic bus_clk_en,
   output logic periph_clk_en,
   input wire logic bus_clock_pin_in,
   output logic bus_clock_pin_out,
   output logic bus_clock_pin_oe_b,
   output logic clock_from_bus_pin,
   input wire logic pause_or_crystal_select_pin,
   output logic clock_pause_request,
   output logic crystal_select
);
   import pcrc_pkg::*;

   initial
   begin
      if (DIV_CNT_W < int'(RATE_TOP))
         $error("pcrc_ctrl: DIV_CNT_W cannot hold the slowest divider period");
   end

   // bits that a mode pins to 1
   function automatic logic [REG_W-1:0] fixed_bits(input logic [MODE_W-1:0] m);
      logic [REG_W-1:0] f;
      f = FIXED_NONE;
      unique case (m)
         MODE_0, MODE_1: f = FIXED_NONE;
         MODE_2, MODE_3: f = FIXED_MODE23;
         MODE_4, MODE_5: f = FIXED_MODE45;
         default: f = FIXED_MODE6;
      endcase
      return f;
   endfunction

   function automatic logic [REG_W-1:0] reset_value(input logic [MODE_W-1:0] m);
      logic [REG_W-1:0] v;
      v = RESET_MODE6;
      unique case (m)
         MODE_0, MODE_1: v = RESET_MODE01;
         MODE_2: v = RESET_MODE2;
         MODE_3: v = RESET_MODE3;
         MODE_4, MODE_5: v = RESET_MODE45;
         default: v = RESET_MODE6;
      endcase
      return v;
   endfunction

   function automatic logic [LOG_W-1:0] sel3(input logic hi, input logic mid,
      input logic [LOG_W-1:0] a, input logic [LOG_W-1:0] b, input logic [LOG_W-1:0] c);
      logic [LOG_W-1:0] r;
      r = hi ? a : (mid ? b : c);
      return r;
   endfunction

   // core, bus, peripheral rates for a code; illegal codes give a harmless rate
   function automatic logic [3*LOG_W-1:0] rates(input logic p1, input logic p2,
      input logic m45, input logic [FR_W-1:0] fr);
      logic [LOG_W-1:0] c;
      logic [LOG_W-1:0] b;
      logic [LOG_W-1:0] p;
      logic bus4;
      bus4 = (fr == FR_BUS4_A) || (fr == FR_BUS4_B);
      c = RATE_1;
      b = RATE_1;
      p = RATE_1;
      if (p1 && p2)
      begin
         c = sel3(fr[3], fr[2], RATE_4, RATE_2, RATE_1);
         b = bus4 ? RATE_4 : ((fr[1] | fr[0]) ? RATE_2 : RATE_1);
         p = fr[1] ? RATE_2 : RATE_1;
      end
      else if (p2)
      begin
         c = sel3(fr[3], fr[2], RATE_4, RATE_2, RATE_1);
         b = c;
         p = fr[1] ? RATE_2 : RATE_1;
      end
      else if (p1 && m45)
      begin
         c = fr[3] ? RATE_2 : RATE_1;
         b = RATE_1;
         p = fr[1] ? RATE_1 : RATE_H;
      end
      else if (p1)
      begin
         c = sel3(fr[3], fr[2], RATE_4, RATE_2, RATE_1);
         b = RATE_1;
         p = RATE_1;
      end
      else if (fr == FR_ALL_ONE)
      begin
         c = RATE_1;
         b = RATE_1;
         p = RATE_1;
      end
      else
      begin
         c = sel3(fr[3], fr[2], RATE_1, RATE_H, RATE_Q);
         b = bus4 ? RATE_1 : ((fr[1] | fr[0]) ? RATE_H : RATE_Q);
         p = fr[1] ? RATE_H : RATE_Q;
      end
      return {c, b, p};
   endfunction

   logic init_done;
   logic [MODE_W-1:0] mode;
   logic [REG_W-1:0] ratio_ctrl;
   logic [REG_W-1:0] applied;
   logic [REG_W-1:0] next_ratio_ctrl;
   logic [REG_W-1:0] fixed;
   logic [REG_W-1:0] ratio_view;
   logic [REG_W-1:0] status_view;
   pcrc_state_t state;
   logic resp;
   logic accept;
   logic take;
   logic wr_ratio;
   logic changes;
   logic m45;
   logic clocks_run;
   logic [3*LOG_W-1:0] rate_vec;
   logic [LOG_W-1:0] shift [3];
   logic [2:0] en_vec;

   assign fixed = fixed_bits(mode);
   assign m45 = (mode == MODE_4) || (mode == MODE_5);
   assign ratio_view = (ratio_ctrl | fixed) & ~RESERVED_MASK;
   assign status_view = {applied[FR_W-1:0], mode, state == PCRC_SETTLE};

   // bus slave: one extra cycle per access; stalls until the register
   // is loaded and while the clocks are held for settling
   assign accept = init_done && (state == PCRC_RUN) && (avs_read || avs_write) && !resp;
   assign take = init_done && (state == PCRC_RUN) && (avs_read || avs_write) && resp;
   assign avs_waitrequest = (avs_read || avs_write) && !take;
   assign wr_ratio = take && avs_write && avs_byteenable[0] && (avs_address == ADDR_RATIO);

   // fixed bits keep their pinned value, reserved bit stays 0
   assign next_ratio_ctrl = ((avs_writedata[REG_W-1:0] & ~fixed) | fixed)
      & ~RESERVED_MASK;
   assign changes = (next_ratio_ctrl[BIT_SECOND_PLL_OFF] != ratio_ctrl[BIT_SECOND_PLL_OFF])
      || (next_ratio_ctrl[BIT_FIRST_PLL_OFF] != ratio_ctrl[BIT_FIRST_PLL_OFF])
      || (next_ratio_ctrl[FR_W-1:0] != ratio_ctrl[FR_W-1:0]);

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         resp <= 1'b0;
      else
         resp <= accept;
   end

   // read data loads at the accept edge so it stands while waitrequest is low

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         avs_readdata <= '0;
      else if (accept && avs_read)
      begin
         if (avs_address == ADDR_RATIO)
            avs_readdata <= DATA_W'(ratio_view);
         else if (avs_address == ADDR_STATUS)
            avs_readdata <= DATA_W'(status_view);
         else
            avs_readdata <= '0;
      end
   end

   // mode pins are caught at the first edge after power-on release,
   // since an async reset may only load constants
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         init_done <= 1'b0;
      else
         init_done <= 1'b1;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         mode <= MODE_0;
      else if (!init_done)
         mode <= mode_pins;
   end

   // watchdog reset deliberately has no effect here
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         ratio_ctrl <= RESET_MODE01;
      else if (!init_done)
         ratio_ctrl <= reset_value(mode_pins);
      else if (wr_ratio)
         ratio_ctrl <= next_ratio_ctrl;
   end

   // switch sequence
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         state <= PCRC_RUN;
      else if (watchdog_reset)
         state <= PCRC_RUN;
      else
      begin
         unique case (state)
            PCRC_RUN:
               if (wr_ratio && changes)
                  state <= PCRC_SETTLE;
            PCRC_SETTLE:
               if (watchdog_settle_overflow)
                  state <= PCRC_RUN;
         endcase
      end
   end

   // the ratio in force only moves at the end of settling or on a watchdog reset
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         applied <= RESET_MODE01;
      else if (!init_done)
         applied <= reset_value(mode_pins);
      else if (watchdog_reset)
         applied <= ratio_ctrl;
      else if ((state == PCRC_SETTLE) && watchdog_settle_overflow)
         applied <= ratio_ctrl;
      else if (wr_ratio && !changes)
         applied <= next_ratio_ctrl;
   end

   // oscillators follow the programmed state at once and keep running
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         first_pll_run <= 1'b0;
         second_pll_run <= 1'b0;
      end
      else
      begin
         first_pll_run <= init_done && !ratio_view[BIT_FIRST_PLL_OFF];
         second_pll_run <= init_done && !ratio_view[BIT_SECOND_PLL_OFF];
      end
   end

   // settle time is counted by the watchdog; its overflow must not look
   // like a real timeout, so flags, interrupt and output are suppressed
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         watchdog_count_enable <= 1'b0;
         watchdog_flags_suppress <= 1'b0;
      end
      else
      begin
         watchdog_count_enable <= (state == PCRC_RUN) ? (wr_ratio && changes)
            : !watchdog_settle_overflow;
         watchdog_flags_suppress <= (state == PCRC_RUN) ? (wr_ratio && changes)
            : 1'b1;
      end
   end

   assign clocks_run = init_done && (state == PCRC_RUN);
   assign rate_vec = rates(!applied[BIT_FIRST_PLL_OFF], !applied[BIT_SECOND_PLL_OFF], m45,
      applied[FR_W-1:0]);

   // one divider per internal clock; reference rate stands for x4
   generate
      for (genvar i = 0; i < 3; i++)
      begin : g_div
         assign shift[i] = RATE_TOP - rate_vec[i*LOG_W +: LOG_W];
         pcrc_clk_div #(
            .CNT_W(DIV_CNT_W)
         ) u_div (
            .ref_clk(ref_clk),
            .rst_b(rst_b),
            .run(clocks_run),
            .shift(shift[i]),
            .clk_en(en_vec[i])
         );
      end
   endgenerate

   assign periph_clk_en = en_vec[0];
   assign bus_clk_en = en_vec[1];
   assign core_clk_en = en_vec[2];

   // bus clock pin: output of the bus clock in modes 0-3 unless set hi-z
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bus_clock_pin_out <= 1'b0;
         bus_clock_pin_oe_b <= 1'b1;
      end
      else
      begin
         bus_clock_pin_out <= en_vec[1];
         bus_clock_pin_oe_b <= !init_done || ratio_view[BIT_BUS_CLOCK_PIN_HIZ];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         clock_from_bus_pin <= 1'b0;
         clock_pause_request <= 1'b0;
         crystal_select <= 1'b0;
      end
      else
      begin
         clock_from_bus_pin <= mode[2];
         clock_pause_request <= mode[2] && pause_or_crystal_select_pin;
         crystal_select <= !mode[2] && pause_or_crystal_select_pin;
      end
   end

   // the pin is an input in modes 4-6 and its level is only observed
   logic bus_pin_seen;
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         bus_pin_seen <= 1'b0;
      else
         bus_pin_seen <= bus_clock_pin_in && mode[2];
   end
endmodule // pcrc_ctrl

// file: tb/pcrc_ctrl_asserts.sv
// port-level assertions for the clock ratio control block
`timescale 1ns/100ps
module pcrc_ctrl_asserts #(
   parameter int unsigned DIV_CNT_W = 4
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [pcrc_pkg::MODE_W-1:0] mode_pins,
   input wire logic [pcrc_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [pcrc_pkg::DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic watchdog_settle_overflow,
   input wire logic watchdog_count_enable,
   input wire logic watchdog_flags_suppress,
   input wire logic core_clk_en,
   input wire logic bus_clk_en,
   input wire logic periph_clk_en,
   input wire logic bus_clock_pin_oe_b,
   input wire logic clock_from_bus_pin,
   input wire logic pause_or_crystal_select_pin,
   input wire logic clock_pause_request,
   input wire logic crystal_select
);
   import pcrc_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   logic tk_rd;
   logic [1:0] up_cnt;
   assign tk_rd = avs_read && !avs_waitrequest && avs_address == ADDR_RATIO;
   // mode outputs only settle two edges after release
   always_ff @(posedge ref_clk or negedge rst_b)
      if (!rst_b)
         up_cnt <= 2'h0;
      else if (up_cnt != 2'h3)
         up_cnt <= up_cnt + 2'h1;
   property p_rsvd;
      tk_rd |-> avs_readdata[4] == 1'b0 && avs_readdata[31:8] == 24'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
   property p_fix75;
      tk_rd && mode_pins[2] |-> avs_readdata[7] && avs_readdata[5];
   endproperty
   a_fix75: assert property (p_fix75) else $error("bits 7 or 5 not fixed");
   property p_fix6;
      tk_rd && (mode_pins inside {3'h2, 3'h3, 3'h6}) |-> avs_readdata[6];
   endproperty
   a_fix6: assert property (p_fix6) else $error("bit 6 not fixed");
   property p_src;
      up_cnt == 2'h3 |-> clock_from_bus_pin == mode_pins[2];
   endproperty
   a_src: assert property (p_src) else $error("clock source wrong");
   property p_pause;
      up_cnt == 2'h3 |->
         clock_pause_request == (mode_pins[2] && $past(pause_or_crystal_select_pin))
         && crystal_select == (!mode_pins[2] && $past(pause_or_crystal_select_pin));
   endproperty
   a_pause: assert property (p_pause) else $error("shared pin use wrong");
   property p_pin_in;
      up_cnt == 2'h3 && mode_pins[2] |-> bus_clock_pin_oe_b;
   endproperty
   a_pin_in: assert property (p_pin_in) else $error("pin driven in input mode");
   property p_stop;
      watchdog_count_enable && $past(watchdog_count_enable)
         |-> !(core_clk_en || bus_clk_en || periph_clk_en);
   endproperty
   a_stop: assert property (p_stop) else $error("clocks run while settling");
   property p_stall;
      watchdog_count_enable && $past(watchdog_count_enable) && (avs_read || avs_write)
         |-> avs_waitrequest;
   endproperty
   a_stall: assert property (p_stall) else $error("bus taken while settling");
   property p_supp;
      watchdog_count_enable |-> watchdog_flags_suppress;
   endproperty
   a_supp: assert property (p_supp) else $error("flags not suppressed");
   property p_done;
      watchdog_settle_overflow && watchdog_count_enable |-> ##[1:3] !watchdog_count_enable;
   endproperty
   a_done: assert property (p_done) else $error("settle not ended");
   c_wr: cover property (avs_write && !avs_waitrequest);
   c_settle: cover property (watchdog_settle_overflow && watchdog_count_enable);
   c_rd45: cover property (tk_rd && mode_pins[2]);
endmodule // pcrc_ctrl_asserts

bind pcrc_ctrl pcrc_ctrl_asserts #(.DIV_CNT_W(DIV_CNT_W)) i_pcrc_ctrl_asserts (.*);

// file: tb/pcrc_far_model.sv
// watchdog settle timer and external clock source beside the block
`timescale 1ns/100ps
module pcrc_far_model (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic slow,
   input wire logic watchdog_count_enable,
   input wire logic clock_from_bus_pin,
   input wire logic bus_clock_pin_out,
   input wire logic bus_clock_pin_oe_b,
   output logic watchdog_settle_overflow,
   output logic bus_clock_pin_in,
   output logic pause_or_crystal_select_pin
);
   logic [7:0] cnt;
   logic [3:0] ext_cnt;
   // settle count only advances while fed; one-cycle overflow pulse
   always_ff @(posedge ref_clk or negedge rst_b)
      if (!rst_b)
      begin
         cnt <= 8'h00;
         watchdog_settle_overflow <= 1'b0;
      end
      else if (!watchdog_count_enable)
      begin
         cnt <= 8'h00;
         watchdog_settle_overflow <= 1'b0;
      end
      else
      begin
         cnt <= cnt + 8'h01;
         watchdog_settle_overflow <= (cnt == (slow ? 8'h28 : 8'h04));
      end
   always_ff @(posedge ref_clk or negedge rst_b)
      if (!rst_b)
         ext_cnt <= 4'h0;
      else
         ext_cnt <= ext_cnt + 4'h1;
   assign pause_or_crystal_select_pin = ext_cnt[3];
   // released pin shows a changing pattern, not the last level
   assign bus_clock_pin_in = clock_from_bus_pin ? ext_cnt[0] :
      (bus_clock_pin_oe_b ? ext_cnt[1] : bus_clock_pin_out);
endmodule // pcrc_far_model

// file: tb/test_pcrc_ctrl.sv
// register, mode and clock ratio tests for the ratio control block
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
   begin \
      tests_run++; \
      if ((got) !== (ex)) \
         $display("ERROR %s exp %h got %h", nm, ex, got); \
      if ((got) !== (ex)) \
         error_cnt++; \
   end
module test_pcrc_ctrl;
   import pcrc_pkg::*;
   logic ref_clk = 1'b0, rst_b = 1'b0, watchdog_reset = 1'b0, slow = 1'b0;
   logic [2:0] mode_pins = 3'h0;
   logic [31:0] avs_address = 32'h0, avs_writedata = 32'h0, avs_readdata, d;
   logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic wso, wce, wfs, p1, p2, ce, be, pe, pin_in, pin_out, oe_b, cfb, psel, pr, xs;
   logic [7:0] cc, cb, cp;
   int error_cnt = 0, tests_run = 0, cyc = 0;
   logic [7:0] rst_v [7] = '{8'h00, 8'h00, 8'h40, 8'h60, 8'ha6, 8'ha6, 8'he0};
   logic [7:0] wr_v [7] = '{8'h0c, 8'h08, 8'h0e, 8'h00, 8'h06, 8'h49, 8'h0f};
   logic [7:0] ex_v [7] = '{8'h0c, 8'h08, 8'h4e, 8'h40, 8'ha6, 8'he9, 8'hef};
   logic [7:0] n_c [7] = '{8'h40, 8'h40, 8'h40, 8'h10, 8'h10, 8'h10, 8'h10};
   logic [7:0] n_b [7] = '{8'h40, 8'h10, 8'h40, 8'h10, 8'h10, 8'h08, 8'h10};
   logic [7:0] n_p [7] = '{8'h10, 8'h10, 8'h20, 8'h10, 8'h10, 8'h04, 8'h10};
   always #20 ref_clk = ~ref_clk;
   pcrc_ctrl i_pcrc_ctrl (.ref_clk(ref_clk), .rst_b(rst_b), .watchdog_reset(watchdog_reset),
      .mode_pins(mode_pins), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .watchdog_settle_overflow(wso), .watchdog_count_enable(wce),
      .watchdog_flags_suppress(wfs), .first_pll_run(p1), .second_pll_run(p2),
      .core_clk_en(ce), .bus_clk_en(be), .periph_clk_en(pe), .bus_clock_pin_in(pin_in),
      .bus_clock_pin_out(pin_out), .bus_clock_pin_oe_b(oe_b), .clock_from_bus_pin(cfb),
      .pause_or_crystal_select_pin(psel), .clock_pause_request(pr), .crystal_select(xs));
   pcrc_far_model i_pcrc_far_model (.ref_clk(ref_clk), .rst_b(rst_b), .slow(slow),
      .watchdog_count_enable(wce), .clock_from_bus_pin(cfb), .bus_clock_pin_out(pin_out),
      .bus_clock_pin_oe_b(oe_b), .watchdog_settle_overflow(wso), .bus_clock_pin_in(pin_in),
      .pause_or_crystal_select_pin(psel));
   task report_and_stop;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
         if (error_cnt == 0 && tests_run > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         report_and_stop;
      end
   end
   // request held until waitrequest is sampled low at a rising edge;
   // the leading edge keeps two calls from driving one signal twice at once
   task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      begin
         @(posedge ref_clk);
         avs_address <= a;
         avs_writedata <= wd;
         avs_read <= !wr;
         avs_write <= wr;
         @(posedge ref_clk);
         while (avs_waitrequest !== 1'b0)
            @(posedge ref_clk);
         d = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
      end
   endtask
   initial
   begin
      for (int m = 0; m < 7; m++)
      begin
         @(posedge ref_clk);
         rst_b <= 1'b0;
         mode_pins <= m[2:0];
         slow <= m[0];
         repeat (16) @(posedge ref_clk);
         rst_b <= 1'b1;
         bus(1'b0, ADDR_RATIO, 32'h0);
         `CHK("reset value", {24'h0, rst_v[m]}, d)
         bus(1'b1, ADDR_RATIO, {24'h0, wr_v[m]});
         repeat (8) @(posedge ref_clk);
         bus(1'b0, ADDR_RATIO, 32'h0);
         `CHK("ratio reg", {24'h0, ex_v[m]}, d)
         bus(1'b0, ADDR_STATUS, 32'h0);
         `CHK("status", {24'h0, ex_v[m][3:0], m[2:0], 1'b0}, d)
         `CHK("pin oe_b", ex_v[m][5], oe_b)
         `CHK("pll runs", ~ex_v[m][7:6], {p2, p1})
         cc = 8'h00;
         cb = 8'h00;
         cp = 8'h00;
         repeat (64)
         begin
            @(negedge ref_clk);
            cc += {7'h0, ce};
            cb += {7'h0, be};
            cp += {7'h0, pe};
         end
         `CHK("core rate", n_c[m], cc)
         `CHK("bus rate", n_b[m], cb)
         `CHK("periph rate", n_p[m], cp)
         @(posedge ref_clk);
         watchdog_reset <= 1'b1;
         @(posedge ref_clk);
         watchdog_reset <= 1'b0;
         bus(1'b0, ADDR_RATIO, 32'h0);
         `CHK("kept on wdt reset", {24'h0, ex_v[m]}, d)
         bus(1'b0, 32'hfffffe98, 32'h0);
         `CHK("unmapped", 32'h0, d)
         $display("mode %0d test done", m);
      end
      report_and_stop;
   end
endmodule // test_pcrc_ctrl
